// ### core/crg_pkg.sv
// package for the conversion result and general pin control register bank
// assumes one clock domain; every file that uses names here refers to them as crg_pkg::name
`default_nettype none

package crg_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int WORD_W       = 16;
  localparam int RESULT_W     = 12;
  localparam int RADDR_W      = 5;
  localparam int WADDR_W      = 4;
  localparam int GPIO_W       = 8;
  localparam int RESULT_COUNT = 9;
  localparam int PIN_COUNT    = 2;
  localparam int COUNT_W      = 4;

  // ----------------------------------------------------------------
  // read addresses
  // ----------------------------------------------------------------
  localparam logic [RADDR_W-1:0] RADDR_PRESSURE_SECOND = 5'h12;
  localparam logic [RADDR_W-1:0] RADDR_AUX_ONE         = 5'h13;
  localparam logic [RADDR_W-1:0] RADDR_AUX_TWO         = 5'h14;
  localparam logic [RADDR_W-1:0] RADDR_AUX_THREE       = 5'h15;
  localparam logic [RADDR_W-1:0] RADDR_BATTERY_ONE     = 5'h16;
  localparam logic [RADDR_W-1:0] RADDR_BATTERY_TWO     = 5'h17;
  localparam logic [RADDR_W-1:0] RADDR_TEMP_SINGLE     = 5'h18;
  localparam logic [RADDR_W-1:0] RADDR_TEMP_DIFF       = 5'h19;
  localparam logic [RADDR_W-1:0] RADDR_PRESSURE_FIRST  = 5'h1a;
  localparam logic [RADDR_W-1:0] RADDR_GPIO_CTRL_FIRST = 5'h1b;

  // ----------------------------------------------------------------
  // write word layout
  // ----------------------------------------------------------------
  localparam logic [WADDR_W-1:0] WADDR_EXTENDED      = 4'hf;
  localparam logic [WADDR_W-1:0] WADDR_CONTROL_FIRST = 4'h1;
  localparam logic [WADDR_W-1:0] EXT_GPIO_CTRL_FIRST = 4'h0;
  localparam int WORD_ADDR_LSB = 12;
  localparam int EXT_ADDR_LSB  = 8;
  localparam int READ_SEL_LSB  = 2;
  localparam logic [COUNT_W-1:0] LAST_BIT = 4'hf;

  // ----------------------------------------------------------------
  // general pin control fields
  // ----------------------------------------------------------------
  localparam int PIN_B          = 0;
  localparam int PIN_A          = 1;
  localparam int PIN_B_BASE     = 0;
  localparam int PIN_A_BASE     = 4;
  localparam int FLD_ALARM_EN   = 0;
  localparam int FLD_DIRECTION  = 1;
  localparam int FLD_POLARITY   = 2;
  localparam int FLD_FUNCTION   = 3;
  localparam logic DIR_INPUT    = 1'b1;
  localparam logic FUNC_GPIO    = 1'b1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [RESULT_W-1:0] RESULT_RESET    = 12'h000;
  localparam logic [GPIO_W-1:0]   GPIO_CTRL_RESET = 8'h00;
  localparam logic [RADDR_W-1:0]  READ_SEL_RESET  = 5'h00;
  localparam logic [WORD_W-1:0]   WORD_RESET      = 16'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                valid;
    logic [RADDR_W-1:0]  chan;
    logic [RESULT_W-1:0] value;
  } crg_result_s;

  typedef struct packed {
    logic alarm_en;
    logic direction;
    logic polarity;
    logic function_sel;
  } crg_pin_cfg_s;

endpackage

`default_nettype wire

// ### core/crg_regbank.sv
// conversion result registers and first general pin control register
// assumes converter results arrive as one-cycle strobes on clk_sys
// Function
// - second pressure result, read-only 12 bits at read address 10010, resets zero
// - first pressure result, read-only 12 bits at read address 11010
// - auxiliary results one to three at 10011, 10100, 10101, read-only, zero reset
// - battery results one and two at 10110 and 10111, read-only, zero reset
// - temperature single-ended at 11000, differential at 11001, read-only
// - write word prefix 1111b selects the extended write map
// - extended write: four address bits then eight data bits
// - reads: write 5-bit read address to control register one, then shift out
// - pin control register written at extended 0000, read at 11011, zero reset
// - bit 0 enables pin b as alarm source, clear masks it
// - bit 1 sets pin b direction: 0 output, 1 input
// - polarity bit makes pin b active low at 0, high at 1
// - bit 3 selects pin b function: 0 analog input two, 1 general pin
// - bit 4 enables pin a as alarm source, clear masks it
// - bit 5 sets pin a direction: 0 output, 1 input
// - bit 6 makes pin a active low at 0, high at 1
// - bit 7 selects pin a function: 0 analog input one, 1 general pin
`default_nettype none

module crg_regbank
(
  // clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            reset_n,
  input  wire logic                            clk_en,
  // serial pins
  input  wire logic                            serial_clock,
  input  wire logic                            select_n,
  input  wire logic                            data_in,
  output var  logic                            data_out,
  // converter results
  input  wire crg_pkg::crg_result_s            result_in,
  // general pins, index 1 is pin a, index 0 is pin b
  input  wire logic [crg_pkg::PIN_COUNT-1:0]   pin_in,
  input  wire logic [crg_pkg::PIN_COUNT-1:0]   pin_drive_level,
  output var  logic [crg_pkg::PIN_COUNT-1:0]   pin_out,
  output var  logic [crg_pkg::PIN_COUNT-1:0]   pin_oe_n,
  output var  logic [crg_pkg::PIN_COUNT-1:0]   aux_route,
  // alarm
  output var  logic                            alarm
);

  logic [crg_pkg::RESULT_W-1:0]  results [crg_pkg::RESULT_COUNT];
  logic [crg_pkg::GPIO_W-1:0]    gpio_ctrl;
  logic [crg_pkg::RADDR_W-1:0]   read_sel;
  logic [crg_pkg::WORD_W-1:0]    shift_word;
  logic                          word_valid;
  logic [crg_pkg::WORD_W-1:0]    word;
  logic [crg_pkg::WADDR_W-1:0]   word_addr;
  logic [crg_pkg::WADDR_W-1:0]   ext_addr;
  logic                          ext_ctrl_write;
  logic                          read_sel_write;
  logic [crg_pkg::PIN_COUNT-1:0] next_alarm_src;
  crg_pkg::crg_pin_cfg_s         pin_view [crg_pkg::PIN_COUNT];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic result_hit(input logic [crg_pkg::RADDR_W-1:0] addr);
    result_hit = addr >= crg_pkg::RADDR_PRESSURE_SECOND &&
                 addr <= crg_pkg::RADDR_PRESSURE_FIRST;
  endfunction

  function automatic logic [3:0] result_index(input logic [crg_pkg::RADDR_W-1:0] addr);
    logic [crg_pkg::RADDR_W-1:0] diff;
    diff         = addr - crg_pkg::RADDR_PRESSURE_SECOND;
    result_index = diff[3:0];
  endfunction

  function automatic crg_pkg::crg_pin_cfg_s pin_cfg(input logic [crg_pkg::GPIO_W-1:0] ctrl,
                                                   input int pin);
    int base;
    base                 = (pin == crg_pkg::PIN_A) ? crg_pkg::PIN_A_BASE : crg_pkg::PIN_B_BASE;
    pin_cfg.alarm_en     = ctrl[base + crg_pkg::FLD_ALARM_EN];
    pin_cfg.direction    = ctrl[base + crg_pkg::FLD_DIRECTION];
    pin_cfg.polarity     = ctrl[base + crg_pkg::FLD_POLARITY];
    pin_cfg.function_sel = ctrl[base + crg_pkg::FLD_FUNCTION];
  endfunction

  // ----------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------
  crg_serial_port u_serial
  (
    .clk_sys      (clk_sys),
    .reset_n      (reset_n),
    .clk_en       (clk_en),
    .serial_clock (serial_clock),
    .select_n     (select_n),
    .data_in      (data_in),
    .data_out     (data_out),
    .shift_word   (shift_word),
    .word_valid   (word_valid),
    .word         (word)
  );

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign word_addr      = word[crg_pkg::WORD_W-1:crg_pkg::WORD_ADDR_LSB];
  assign ext_addr       = word[crg_pkg::WORD_ADDR_LSB-1:crg_pkg::EXT_ADDR_LSB];
  assign ext_ctrl_write = word_valid && word_addr == crg_pkg::WADDR_EXTENDED
                          && ext_addr == crg_pkg::EXT_GPIO_CTRL_FIRST;
  assign read_sel_write = word_valid && word_addr == crg_pkg::WADDR_CONTROL_FIRST;

  // read address pointer
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      read_sel <= crg_pkg::READ_SEL_RESET;
    else if (clk_en && read_sel_write)
      read_sel <= word[crg_pkg::READ_SEL_LSB +: crg_pkg::RADDR_W];
  end

  // pin control register, data in the low eight bits
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      gpio_ctrl <= crg_pkg::GPIO_CTRL_RESET;
    else if (clk_en && ext_ctrl_write)
      gpio_ctrl <= word[crg_pkg::GPIO_W-1:0];
  end

  // ----------------------------------------------------------------
  // result storage: only the converter writes it, never the host
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < crg_pkg::RESULT_COUNT; i++)
        results[i] <= crg_pkg::RESULT_RESET;
    end
    else if (clk_en && result_in.valid && result_hit(result_in.chan))
      results[result_index(result_in.chan)] <= result_in.value;
  end

  // ----------------------------------------------------------------
  // read mux, zero-extended into the outgoing word
  // ----------------------------------------------------------------
  always_comb
  begin
    shift_word = crg_pkg::WORD_RESET;
    if (result_hit(read_sel))
      shift_word[crg_pkg::RESULT_W-1:0] = results[result_index(read_sel)];
    else if (read_sel == crg_pkg::RADDR_GPIO_CTRL_FIRST)
      shift_word[crg_pkg::GPIO_W-1:0] = gpio_ctrl;
  end

  // ----------------------------------------------------------------
  // pin control; the pin only drives as a general output, so an
  // analog input never fights the output stage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_out   <= '0;
      pin_oe_n  <= '1;
      aux_route <= '1;
    end
    else if (clk_en)
    begin
      for (int p = 0; p < crg_pkg::PIN_COUNT; p++)
      begin
        aux_route[p] <= pin_view[p].function_sel != crg_pkg::FUNC_GPIO;
        pin_oe_n[p]  <= !(pin_view[p].function_sel == crg_pkg::FUNC_GPIO &&
                          pin_view[p].direction != crg_pkg::DIR_INPUT);
        pin_out[p]   <= pin_view[p].polarity ? pin_drive_level[p]
                                             : !pin_drive_level[p];
      end
    end
  end

  // ----------------------------------------------------------------
  // alarm: registered level, not latched, so it drops one clock after the pin does
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int p = 0; p < crg_pkg::PIN_COUNT; p++)
    begin
      pin_view[p]       = pin_cfg(gpio_ctrl, p);
      next_alarm_src[p] = pin_view[p].alarm_en &&
                          pin_view[p].direction == crg_pkg::DIR_INPUT &&
                          pin_view[p].function_sel == crg_pkg::FUNC_GPIO &&
                          pin_in[p] == pin_view[p].polarity;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      alarm <= 1'b0;
    else if (clk_en)
      alarm <= |next_alarm_src;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_RESULT_CAPTURE: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && result_in.valid && result_in.chan == crg_pkg::RADDR_PRESSURE_SECOND
    |=> results[0] == $past(result_in.value))
    else $error("second pressure result not captured");

  AST_RESULT_READ: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    read_sel == crg_pkg::RADDR_PRESSURE_FIRST
    |-> shift_word == {4'h0, results[8]})
    else $error("first pressure result not on read word");

  AST_RESULT_HOLD: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    !result_in.valid |=> $stable(results[1]) && $stable(results[2]) && $stable(results[3]))
    else $error("auxiliary result changed without converter strobe");

  AST_BATTERY_READ: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    read_sel == crg_pkg::RADDR_BATTERY_TWO |-> shift_word[11:0] == results[5])
    else $error("battery two result not on read word");

  AST_TEMP_READ: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    read_sel == crg_pkg::RADDR_TEMP_DIFF |-> shift_word[11:0] == results[7])
    else $error("differential temperature not on read word");

  AST_EXT_WRITE: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && word_valid && word[15:12] == 4'hf && word[11:8] == 4'h0
    |=> gpio_ctrl == $past(word[7:0]))
    else $error("extended write did not reach pin control");

  AST_EXT_OTHER: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    word_valid && (word[15:12] != 4'hf || word[11:8] != 4'h0) |=> $stable(gpio_ctrl))
    else $error("pin control changed on a foreign write");

  AST_READ_SELECT: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && read_sel_write |=> read_sel == $past(word[6:2]))
    else $error("read address not loaded");

  AST_CTRL_READ: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    read_sel == 5'h1b |-> shift_word == {8'h00, gpio_ctrl})
    else $error("pin control not on read word");

  AST_DRIVE_B: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && gpio_ctrl[3] && !gpio_ctrl[1] |=> !pin_oe_n[0])
    else $error("pin b not driving as output");

  AST_ANALOG_A: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && !gpio_ctrl[7] |=> aux_route[1] && pin_oe_n[1])
    else $error("pin a driven while routed to analog");

  AST_ALARM_A: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && gpio_ctrl[7:4] == 4'b1111 && pin_in[1] |=> alarm)
    else $error("active-high pin a failed to raise alarm");

  AST_ALARM_MASK: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && !gpio_ctrl[0] && !gpio_ctrl[4] |=> !alarm)
    else $error("alarm raised with both sources masked");

  AST_ALARM_LOW: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && gpio_ctrl[4] == 1'b0 && gpio_ctrl[3:0] == 4'b1011 && !pin_in[0] |=> alarm)
    else $error("active-low pin b failed to raise alarm");

  AST_POLARITY_A: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && !gpio_ctrl[6] |=> pin_out[1] == !$past(pin_drive_level[1]))
    else $error("active-low pin a not driven inverted");

  AST_DRIVE_A: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && gpio_ctrl[7] && gpio_ctrl[5] |=> pin_oe_n[1])
    else $error("pin a driven while set as input");

  AST_ANALOG_B: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && !gpio_ctrl[3] |=> aux_route[0] && pin_oe_n[0])
    else $error("pin b driven while routed to analog");

  // the read pin rests low between frames so a shared line sees no stray level
  AST_SERIAL_IDLE: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && select_n |=> !data_out)
    else $error("serial output not low outside a frame");

  AST_FREEZE: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    !clk_en |=> $stable(gpio_ctrl) && $stable(read_sel) && $stable(alarm))
    else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// ### core/crg_serial_port.sv
// serial frame shifter: 16-bit words in on data_in, one word out on data_out
// assumes serial pins are synchronous to clk_sys and sclk is much slower
`default_nettype none

module crg_serial_port
(
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        reset_n,
  input  wire logic                        clk_en,
  // serial pins
  input  wire logic                        serial_clock,
  input  wire logic                        select_n,
  input  wire logic                        data_in,
  output var  logic                        data_out,
  // word side
  input  wire logic [crg_pkg::WORD_W-1:0]  shift_word,
  output var  logic                        word_valid,
  output var  logic [crg_pkg::WORD_W-1:0]  word
);

  logic                        clock_q;
  logic                        select_q;
  logic [crg_pkg::COUNT_W-1:0] bit_count;
  logic [crg_pkg::WORD_W-1:0]  shift_in;
  logic [crg_pkg::WORD_W-1:0]  shift_out;
  logic                        rise;
  logic                        fall;
  logic                        frame_start;

  assign rise        = serial_clock & ~clock_q & ~select_n;
  assign fall        = ~serial_clock & clock_q & ~select_n;
  assign frame_start = select_q & ~select_n;

  // ----------------------------------------------------------------
  // edge history
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clock_q  <= 1'b0;
      select_q <= 1'b1;
    end
    else if (clk_en)
    begin
      clock_q  <= serial_clock;
      select_q <= select_n;
    end
  end

  // ----------------------------------------------------------------
  // receive: msb first on rising edges, word closes on the 16th
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bit_count  <= '0;
      shift_in   <= crg_pkg::WORD_RESET;
      word       <= crg_pkg::WORD_RESET;
      word_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      word_valid <= 1'b0;
      if (select_n)
        bit_count <= '0;
      else if (rise)
      begin
        shift_in  <= {shift_in[crg_pkg::WORD_W-2:0], data_in};
        bit_count <= bit_count + 1'b1;
        if (bit_count == crg_pkg::LAST_BIT)
        begin
          word       <= {shift_in[crg_pkg::WORD_W-2:0], data_in};
          word_valid <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit: word captured at frame start so a mid-frame write
  // cannot tear the value being read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_out <= crg_pkg::WORD_RESET;
      data_out  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (frame_start)
      begin
        data_out  <= shift_word[crg_pkg::WORD_W-1];
        shift_out <= {shift_word[crg_pkg::WORD_W-2:0], 1'b0};
      end
      else if (fall)
      begin
        data_out  <= shift_out[crg_pkg::WORD_W-1];
        shift_out <= {shift_out[crg_pkg::WORD_W-2:0], 1'b0};
      end
      else if (select_n)
        data_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### tb/crg_host_model.sv
// host model: frames 16-bit words on the serial pins and captures data_out
// assumes the device samples every serial pin on clk_sys
`default_nettype none

module crg_host_model
(
  // clock
  input  wire logic clk_sys,
  // serial pins
  output var  logic serial_clock,
  output var  logic select_n,
  output var  logic data_in,
  input  wire logic data_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // each serial level is held well over the two-cycle minimum
  localparam int HALF = 4;

  initial
  begin
    serial_clock = 1'b0;
    select_n     = 1'b1;
    data_in      = 1'b1;
  end

  // the clock idles low between frames; data shows the inverse of the last bit once released
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge clk_sys);
    select_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      data_in <= tx[i];
      repeat (HALF) @(posedge clk_sys);
      rx[i] = data_out;
      serial_clock <= 1'b1;
      repeat (HALF) @(posedge clk_sys);
      serial_clock <= 1'b0;
    end
    repeat (HALF) @(posedge clk_sys);
    select_n <= 1'b1;
    data_in  <= ~tx[0];
    repeat (HALF) @(posedge clk_sys);
  endtask
endmodule

`default_nettype wire

// ### tb/crg_regbank_tb_top.sv
// testbench for the result and general pin control register bank
// assumes the host model drives the serial pins; clk_en drops only in the freeze scenario
`default_nettype none

module crg_regbank_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic                 clk_sys;
  logic                 reset_n;
  logic                 clk_en;
  logic [6:0]           pins_obs;
  logic                 serial_clock;
  logic                 select_n;
  logic                 data_in;
  logic                 data_out;
  logic                 alarm;
  crg_pkg::crg_result_s result_in;
  logic [1:0]           pin_in;
  logic [1:0]           pin_drive_level;
  logic [1:0]           pin_out;
  logic [1:0]           pin_oe_n;
  logic [1:0]           aux_route;
  int                   n_mismatch;
  int                   samples_checked;

  // ----------------------------------------------------------------
  // clock and instances
  // ----------------------------------------------------------------
  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  crg_regbank crg_regbank_i
  (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .serial_clock(serial_clock), .select_n(select_n), .data_in(data_in),
    .data_out(data_out), .result_in(result_in), .pin_in(pin_in),
    .pin_drive_level(pin_drive_level), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .aux_route(aux_route), .alarm(alarm)
  );

  crg_host_model crg_host_model_i
  (
    .clk_sys(clk_sys), .serial_clock(serial_clock), .select_n(select_n),
    .data_in(data_in), .data_out(data_out)
  );

  assign pins_obs = {alarm, aux_route, pin_oe_n, pin_out};

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_pins(input logic [6:0] got, input logic [6:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t pins got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a read needs one frame to set the address and a second to shift the word out
  task automatic read_reg(input logic [4:0] addr, output logic [15:0] rx);
    logic [15:0] dummy;
    crg_host_model_i.frame({4'h1, 5'h00, addr, 2'b00}, dummy);
    crg_host_model_i.frame(16'h0000, rx);
  endtask

  task automatic write_ext(input logic [3:0] ea, input logic [7:0] v);
    logic [15:0] dummy;
    crg_host_model_i.frame({4'hf, ea, v}, dummy);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values();
    logic [15:0] rx;
    for (int a = 'h11; a <= 'h1b; a++)
    begin
      read_reg(a[4:0], rx);
      check_word(rx, 16'h0000);
    end
    $display("test reset values done");
  endtask

  task automatic test_results();
    logic [15:0] rx;
    logic [15:0] exp;
    for (int a = 'h11; a <= 'h1b; a++)
    begin
      @(posedge clk_sys);
      result_in <= {1'b1, a[4:0], a[4:0], 7'h2a};
      @(posedge clk_sys);
      result_in <= '0;
    end
    for (int a = 'h11; a <= 'h1a; a++)
    begin
      read_reg(a[4:0], rx);
      exp = (a == 'h11) ? 16'h0000 : {4'h0, a[4:0], 7'h2a};
      check_word(rx, exp);
    end
    read_reg(5'h1b, rx);
    check_word(rx, 16'h0000);
    $display("test results done");
  endtask

  task automatic test_ctrl_write();
    logic [15:0] rx;
    write_ext(4'h0, 8'ha5);
    read_reg(5'h1b, rx);
    check_word(rx, 16'h00a5);
    write_ext(4'h1, 8'h3c);
    read_reg(5'h1b, rx);
    check_word(rx, 16'h00a5);
    $display("test control write done");
  endtask

  function automatic logic [6:0] pins_exp(logic [7:0] c, logic [1:0] pi, logic [1:0] dv);
    logic [3:0] f;
    logic [1:0] aux;
    logic [1:0] oe;
    logic [1:0] po;
    logic       al;
    al = 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      f      = c[p*4 +: 4];
      aux[p] = ~f[3];
      oe[p]  = ~(f[3] & ~f[1]);
      po[p]  = f[2] ? dv[p] : ~dv[p];
      al     = al | (f[3] & f[1] & f[0] & (pi[p] == f[2]));
    end
    return {al, aux, oe, po};
  endfunction

  task automatic test_pins();
    logic [7:0] cfgs [8];
    logic [6:0] exp;
    cfgs = '{8'h00, 8'h88, 8'hcc, 8'hff, 8'hbb, 8'hab, 8'h7f, 8'hf7};
    foreach (cfgs[k])
    begin
      write_ext(4'h0, cfgs[k]);
      for (int pi = 0; pi < 4; pi++)
      begin
        @(posedge clk_sys);
        pin_in          <= pi[1:0];
        pin_drive_level <= pi[1:0] ^ 2'b01;
        repeat (3) @(posedge clk_sys);
        exp = pins_exp(cfgs[k], pi[1:0], pi[1:0] ^ 2'b01);
        check_pins(pins_obs, exp);
      end
    end
    $display("test pins done");
  endtask

  // a converter strobe while frozen must be lost; then reset in mid-run
  task automatic test_hold_reset();
    logic [15:0] rx;
    @(posedge clk_sys);
    clk_en    <= 1'b0;
    result_in <= {1'b1, 5'h13, 12'h5a5};
    @(posedge clk_sys);
    clk_en    <= 1'b1;
    result_in <= '0;
    read_reg(5'h13, rx);
    check_word(rx, 16'h09aa);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    check_pins(pins_obs, 7'h3c);
    read_reg(5'h1b, rx);
    check_word(rx, 16'h0000);
    read_reg(5'h13, rx);
    check_word(rx, 16'h0000);
    $display("test hold and reset done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    n_mismatch      = 0;
    samples_checked = 0;
    reset_n         = 1'b0;
    clk_en          = 1'b1;
    result_in       = '0;
    pin_in          = 2'b00;
    pin_drive_level = 2'b00;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    test_reset_values();
    test_results();
    test_ctrl_write();
    test_pins();
    test_hold_reset();
    wrap_up();
  end

  // the run needs roughly 9000 cycles; the limit leaves wide margin
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule

`default_nettype wire
